// ===== logic/exec_core.sv
// instruction execution unit with flags, branch timing and register bus
// Notes on behaviour
// - accumulator adds: one cycle, accumulator flags only
// - add with carry includes carry, sets five flags
// - single arithmetic shift keeps sign, sets four flags
// - register-count shift touches only negative and zero
// - literal-count shift writes separate destination, N Z
// - branches: one cycle untaken, four taken
// - accumulator overflow and saturation branch conditions
// - peripheral register read or modify adds one cycle
// - accumulator operations only in motor variant
//
// Decided for this implementation: the Avalon-MM register port and the register addresses.
module exec_core
  import exec_pkg::*;
#(
  parameter bit MOTOR_VARIANT = 1'b1
)
(
  // clock and reset
  input  wire logic                       CLK_IN,
  input  wire logic                       ARST_N_IN,
  // avalon-mm slave
  input  wire logic [exec_pkg::ADDR_W-1:0] AVS_ADDRESS_IN,
  input  wire logic                       AVS_READ_IN,
  input  wire logic                       AVS_WRITE_IN,
  input  wire logic [31:0]                AVS_WRITEDATA_IN,
  output logic      [31:0]                AVS_READDATA_OUT,
  output logic                            AVS_WAITREQUEST_OUT
);

  import exec_pkg::*;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN  = 2'b10
  } state_t;

  // ****************************************
  // state
  // ****************************************
  state_t             state;
  logic [2:0]         cnt;
  op_t                cmd_op;
  cond_t              cmd_cond;
  logic               cmd_sfr;
  logic               cmd_dest_f;
  logic [4:0]         cmd_lit;
  logic               cmd_acc_sel;
  logic [DATA_W-1:0]  opa;
  logic [DATA_W-1:0]  opb;
  logic [DATA_W-1:0]  result;
  logic [DATA_W-1:0]  flags;
  logic [DATA_W-1:0]  pc;
  logic [ACC_W-1:0]   acc_a;
  logic [ACC_W-1:0]   acc_b;
  logic               illegal;
  logic               taken;
  logic [2:0]         last_cycles;

  logic [DATA_W-1:0]  alu_result;
  logic [DATA_W-1:0]  alu_flags;
  logic [ACC_W-1:0]   alu_acc;
  logic               take;
  logic               acc_cond;
  logic               is_acc_op;
  logic               bad_op;
  logic [2:0]         need;
  logic               finish;
  logic               accept;
  logic               do_wr;
  logic [31:0]        next_readdata;

  // ****************************************
  // datapath instances
  // ****************************************
  exec_alu u_alu (
    .op_in      (cmd_op),
    .lit_in     (cmd_lit),
    .acc_sel_in (cmd_acc_sel),
    .a_in       (opa),
    .b_in       (opb),
    .flags_in   (flags),
    .acc_a_in   (acc_a),
    .acc_b_in   (acc_b),
    .result_out (alu_result),
    .flags_out  (alu_flags),
    .acc_out    (alu_acc)
  );

  branch_cond u_cond (
    .cond_in      (cmd_cond),
    .flags_in     (flags),
    .take_out     (take),
    .acc_cond_out (acc_cond)
  );

  // ****************************************
  // cycle count decode
  // ****************************************
  always_comb
  begin
    is_acc_op = (cmd_op == OP_ACC_ADD) || (cmd_op == OP_ACC_SADD);
    bad_op    = (cmd_op > OP_BRANCH) || (!MOTOR_VARIANT && is_acc_op)
              || (!MOTOR_VARIANT && cmd_op == OP_BRANCH && acc_cond);
    if (bad_op)
      need = CYC_ONE;
    else if (cmd_op == OP_BRANCH)
      need = take ? CYC_TAKEN : CYC_ONE;
    else if (is_acc_op)
      need = CYC_ONE;
    else
      need = cmd_sfr ? CYC_ONE + CYC_SFR : CYC_ONE;
    finish = (state == ST_RUN) && (cnt + 3'h1 == need);
  end

  // ****************************************
  // sequencer
  // ****************************************
  always_ff @(posedge CLK_IN or negedge ARST_N_IN)
  begin
    if (!ARST_N_IN)
    begin
      state <= ST_IDLE;
      cnt   <= 3'h0;
    end
    else
    begin
      case (state)
        ST_IDLE:
          if (do_wr && AVS_ADDRESS_IN == OFS_CMD)
          begin
            state <= ST_RUN;
            cnt   <= 3'h0;
          end
        ST_RUN:
          if (finish)
            state <= ST_IDLE;
          else
            cnt <= cnt + 3'h1;
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  // ****************************************
  // command latch
  // ****************************************
  always_ff @(posedge CLK_IN or negedge ARST_N_IN)
  begin
    if (!ARST_N_IN)
    begin
      cmd_op      <= OP_ADD;
      cmd_cond    <= CND_ALWAYS;
      cmd_sfr     <= 1'b0;
      cmd_dest_f  <= 1'b0;
      cmd_lit     <= 5'h00;
      cmd_acc_sel <= 1'b0;
    end
    else if (do_wr && AVS_ADDRESS_IN == OFS_CMD)
    begin
      cmd_op      <= op_t'(AVS_WRITEDATA_IN[CMD_OP_LSB +: 5]);
      cmd_cond    <= cond_t'(AVS_WRITEDATA_IN[CMD_COND_LSB +: 5]);
      cmd_sfr     <= AVS_WRITEDATA_IN[CMD_SFR];
      cmd_dest_f  <= AVS_WRITEDATA_IN[CMD_DEST_F];
      cmd_lit     <= AVS_WRITEDATA_IN[CMD_LIT_LSB +: 5];
      cmd_acc_sel <= AVS_WRITEDATA_IN[CMD_ACC_SEL];
    end
  end

  // ****************************************
  // operands and results
  // ****************************************
  always_ff @(posedge CLK_IN or negedge ARST_N_IN)
  begin
    if (!ARST_N_IN)
    begin
      opa    <= RST_DATA;
      opb    <= RST_DATA;
      result <= RST_DATA;
      acc_a  <= RST_ACC;
      acc_b  <= RST_ACC;
    end
    else if (finish && !bad_op)
    begin
      if (is_acc_op && cmd_acc_sel)
        acc_b <= alu_acc;
      else if (is_acc_op)
        acc_a <= alu_acc;
      else if (cmd_op == OP_BRANCH)
        result <= result;
      else if (cmd_dest_f && cmd_op != OP_ASR_W && cmd_op != OP_ASR_LIT)
        opa <= alu_result;
      else
        result <= alu_result;
    end
    else if (do_wr)
    begin
      if (AVS_ADDRESS_IN == OFS_OPA)
        opa <= AVS_WRITEDATA_IN[DATA_W-1:0];
      else if (AVS_ADDRESS_IN == OFS_OPB)
        opb <= AVS_WRITEDATA_IN[DATA_W-1:0];
      else if (AVS_ADDRESS_IN == OFS_ACCA)
        acc_a <= AVS_WRITEDATA_IN;
      else if (AVS_ADDRESS_IN == OFS_ACCB)
        acc_b <= AVS_WRITEDATA_IN;
    end
  end

  // ****************************************
  // flags
  // ****************************************
  always_ff @(posedge CLK_IN or negedge ARST_N_IN)
  begin
    if (!ARST_N_IN)
      flags <= RST_DATA;
    else if (finish && !bad_op && cmd_op != OP_BRANCH)
      flags <= alu_flags;
    else if (do_wr && AVS_ADDRESS_IN == OFS_FLAGS)
      flags <= AVS_WRITEDATA_IN[DATA_W-1:0];
  end

  // ****************************************
  // program counter and status
  // ****************************************
  always_ff @(posedge CLK_IN or negedge ARST_N_IN)
  begin
    if (!ARST_N_IN)
    begin
      pc          <= RST_DATA;
      illegal     <= 1'b0;
      taken       <= 1'b0;
      last_cycles <= 3'h0;
    end
    else if (finish)
    begin
      illegal     <= bad_op;
      taken       <= (cmd_op == OP_BRANCH) && take && !bad_op;
      last_cycles <= need;
      if ((cmd_op == OP_BRANCH) && take && !bad_op)
        pc <= opa;
      else
        pc <= pc + 16'h0001;
    end
    else if (do_wr && AVS_ADDRESS_IN == OFS_PC)
      pc <= AVS_WRITEDATA_IN[DATA_W-1:0];
  end

  // ****************************************
  // avalon-mm slave
  // ****************************************
  assign accept = (AVS_READ_IN || AVS_WRITE_IN) && AVS_WAITREQUEST_OUT
                && (AVS_READ_IN || state == ST_IDLE);
  assign do_wr  = AVS_WRITE_IN && !AVS_WAITREQUEST_OUT;

  always_comb
  begin
    next_readdata = 32'h0000_0000;
    if (AVS_ADDRESS_IN == OFS_CMD)
      next_readdata = {14'h0000, cmd_acc_sel, cmd_lit, cmd_dest_f, cmd_sfr,
                       cmd_cond, cmd_op};
    else if (AVS_ADDRESS_IN == OFS_OPA)
      next_readdata = {16'h0000, opa};
    else if (AVS_ADDRESS_IN == OFS_OPB)
      next_readdata = {16'h0000, opb};
    else if (AVS_ADDRESS_IN == OFS_RESULT)
      next_readdata = {16'h0000, result};
    else if (AVS_ADDRESS_IN == OFS_FLAGS)
      next_readdata = {16'h0000, flags};
    else if (AVS_ADDRESS_IN == OFS_STAT)
      next_readdata = {26'h0000000, last_cycles, taken, illegal, state == ST_RUN};
    else if (AVS_ADDRESS_IN == OFS_PC)
      next_readdata = {16'h0000, pc};
    else if (AVS_ADDRESS_IN == OFS_ACCA)
      next_readdata = acc_a;
    else if (AVS_ADDRESS_IN == OFS_ACCB)
      next_readdata = acc_b;
  end

  always_ff @(posedge CLK_IN or negedge ARST_N_IN)
  begin
    if (!ARST_N_IN)
    begin
      AVS_WAITREQUEST_OUT <= 1'b1;
      AVS_READDATA_OUT    <= 32'h0000_0000;
    end
    else if (!AVS_WAITREQUEST_OUT)
      AVS_WAITREQUEST_OUT <= 1'b1;
    else if (accept)
    begin
      AVS_WAITREQUEST_OUT <= 1'b0;
      AVS_READDATA_OUT    <= AVS_READ_IN ? next_readdata : 32'h0000_0000;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  sequence s_cmd_issue;
    do_wr && AVS_ADDRESS_IN == OFS_CMD;
  endsequence

  sequence s_run_to_end;
    (state == ST_RUN) ##[0:4] finish;
  endsequence

  a_cmd_runs: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
    s_cmd_issue |=> s_run_to_end) else $error("command did not complete");
  a_add_single: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
    finish && cmd_op == OP_ADD && !cmd_sfr |-> cnt == 3'h0)
    else $error("plain add not one cycle");
  a_sfr_stall: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
    finish && !bad_op && cmd_op < OP_ACC_ADD && cmd_sfr |-> cnt == 3'h1)
    else $error("peripheral access lacks extra cycle");
  a_branch_taken: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
    finish && !bad_op && cmd_op == OP_BRANCH |-> cnt == (take ? 3'h3 : 3'h0))
    else $error("branch timing wrong");
  a_acc_branch: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
    finish && MOTOR_VARIANT && cmd_op == OP_BRANCH && acc_cond && take
    |=> taken && pc == $past(opa))
    else $error("accumulator branch not taken");
  a_branch_flags: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
    finish && cmd_op == OP_BRANCH |=> flags == $past(flags))
    else $error("branch changed flags");
  a_bit_flags: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
    finish && (cmd_op == OP_BIT_CLEAR_OP || cmd_op == OP_BIT_SET_OP) |=> flags == $past(flags))
    else $error("bit operation changed flags");
  a_asr_keep_cv: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
    finish && (cmd_op == OP_ASR_W || cmd_op == OP_ASR_LIT)
    |=> flags[FL_C] == $past(flags[FL_C]) && flags[FL_OV] == $past(flags[FL_OV]))
    else $error("wide shift touched carry or overflow");
  a_lit_dest: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
    finish && cmd_op == OP_ASR_LIT |=> opa == $past(opa)
    && result == $past($signed(opa) >>> cmd_lit))
    else $error("literal shift destination wrong");
  a_asr_sign: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
    finish && cmd_op == OP_ASR1 && !cmd_dest_f
    |=> result[15] == $past(opa[15]) && flags[FL_C] == $past(opa[0]))
    else $error("single shift lost sign or carry");
  a_add_with_carry_sum: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
    finish && cmd_op == OP_ADD_WITH_CARRY && !cmd_dest_f
    |=> result == $past(opa + opb + {15'h0000, flags[FL_C]}))
    else $error("add with carry sum wrong");
  a_acc_flags: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
    finish && is_acc_op |-> cnt == 3'h0 ##1 flags[7:0] == $past(flags[7:0]))
    else $error("accumulator add touched core flags");
  a_variant: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
    finish && !MOTOR_VARIANT && is_acc_op |=> illegal && acc_a == $past(acc_a))
    else $error("accumulator op ran on plain variant");
  a_wait_pulse: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
    !AVS_WAITREQUEST_OUT |=> AVS_WAITREQUEST_OUT)
    else $error("waitrequest low for more than one cycle");

endmodule : exec_core

// ===== logic/exec_pkg.sv
// shared constants and types for the instruction execution block
package exec_pkg;

  // ****************************************
  // widths
  // ****************************************
  localparam int DATA_W = 16;
  localparam int ACC_W  = 32;
  localparam int ADDR_W = 6;

  // ****************************************
  // operations and branch conditions
  // ****************************************
  typedef enum logic [4:0] {
    OP_ADD      = 5'h00,
    OP_ADD_WITH_CARRY     = 5'h01,
    OP_AND      = 5'h02,
    OP_ASR1     = 5'h03,
    OP_ASR_W    = 5'h04,
    OP_ASR_LIT  = 5'h05,
    OP_BIT_CLEAR_OP     = 5'h06,
    OP_BIT_SET_OP     = 5'h07,
    OP_ACC_ADD  = 5'h08,
    OP_ACC_SADD = 5'h09,
    OP_BRANCH   = 5'h0a
  } op_t;

  typedef enum logic [4:0] {
    CND_C    = 5'h00, CND_GE  = 5'h01, CND_GEU = 5'h02, CND_GT  = 5'h03,
    CND_GTU  = 5'h04, CND_LE  = 5'h05, CND_LEU = 5'h06, CND_LT  = 5'h07,
    CND_LTU  = 5'h08, CND_N   = 5'h09, CND_NC  = 5'h0a, CND_NN  = 5'h0b,
    CND_NOV  = 5'h0c, CND_NZ  = 5'h0d, CND_OA  = 5'h0e, CND_OB  = 5'h0f,
    CND_OV   = 5'h10, CND_SA  = 5'h11, CND_SB  = 5'h12, CND_Z   = 5'h13,
    CND_ALWAYS = 5'h14, CND_COMPUTED = 5'h15
  } cond_t;

  // ****************************************
  // flag positions
  // ****************************************
  localparam int FL_C  = 0;
  localparam int FL_Z  = 1;
  localparam int FL_OV = 2;
  localparam int FL_N  = 3;
  localparam int FL_DC = 4;
  localparam int FL_OA = 8;
  localparam int FL_OB = 9;
  localparam int FL_SA = 10;
  localparam int FL_SB = 11;

  // ****************************************
  // command word fields
  // ****************************************
  localparam int CMD_OP_LSB   = 0;
  localparam int CMD_COND_LSB = 5;
  localparam int CMD_SFR      = 10;
  localparam int CMD_DEST_F   = 11;
  localparam int CMD_LIT_LSB  = 12;
  localparam int CMD_ACC_SEL  = 17;

  // ****************************************
  // register byte offsets
  // ****************************************
  localparam logic [ADDR_W-1:0] OFS_CMD    = 6'h00;
  localparam logic [ADDR_W-1:0] OFS_OPA    = 6'h04;
  localparam logic [ADDR_W-1:0] OFS_OPB    = 6'h08;
  localparam logic [ADDR_W-1:0] OFS_RESULT = 6'h0c;
  localparam logic [ADDR_W-1:0] OFS_FLAGS  = 6'h10;
  localparam logic [ADDR_W-1:0] OFS_STAT   = 6'h14;
  localparam logic [ADDR_W-1:0] OFS_PC     = 6'h18;
  localparam logic [ADDR_W-1:0] OFS_ACCA   = 6'h1c;
  localparam logic [ADDR_W-1:0] OFS_ACCB   = 6'h20;

  // ****************************************
  // reset values and cycle counts
  // ****************************************
  localparam logic [DATA_W-1:0] RST_DATA  = 16'h0000;
  localparam logic [ACC_W-1:0]  RST_ACC   = 32'h0000_0000;
  localparam logic [2:0]        CYC_ONE   = 3'h1;
  localparam logic [2:0]        CYC_TAKEN = 3'h4;
  localparam logic [2:0]        CYC_SFR   = 3'h1;

endpackage : exec_pkg

// ===== logic/exec_alu.sv
// combinational datapath: add, shift, bit and accumulator operations
module exec_alu
  import exec_pkg::*;
(
  // operation
  input  wire exec_pkg::op_t          op_in,
  input  wire logic [4:0]             lit_in,
  input  wire logic                   acc_sel_in,
  // operands
  input  wire logic [DATA_W-1:0]      a_in,
  input  wire logic [DATA_W-1:0]      b_in,
  input  wire logic [DATA_W-1:0]      flags_in,
  input  wire logic [ACC_W-1:0]       acc_a_in,
  input  wire logic [ACC_W-1:0]       acc_b_in,
  // results
  output logic      [DATA_W-1:0]      result_out,
  output logic      [DATA_W-1:0]      flags_out,
  output logic      [ACC_W-1:0]       acc_out
);

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [DATA_W-1:0] set_nz(input logic [DATA_W-1:0] f,
                                                input logic [DATA_W-1:0] r);
    logic [DATA_W-1:0] o;
    o = f;
    o[FL_N] = r[DATA_W-1];
    o[FL_Z] = (r == RST_DATA);
    return o;
  endfunction : set_nz

  logic [DATA_W:0]   sum;
  logic [8:0]        low_sum;
  logic              cin;
  logic [ACC_W-1:0]  acc_src;
  logic [ACC_W-1:0]  acc_add;
  logic [ACC_W:0]    acc_sum;
  logic              sat;

  // ****************************************
  // datapath
  // ****************************************
  always_comb
  begin
    cin        = (op_in == OP_ADD_WITH_CARRY) ? flags_in[FL_C] : 1'b0;
    sum        = {1'b0, a_in} + {1'b0, b_in} + {16'h0000, cin};
    low_sum    = {1'b0, a_in[7:0]} + {1'b0, b_in[7:0]} + {8'h00, cin};
    acc_src    = acc_sel_in ? acc_b_in : acc_a_in;
    acc_add    = {{16{a_in[DATA_W-1]}}, a_in};
    if (op_in == OP_ACC_ADD)
      acc_add = acc_sel_in ? acc_a_in : acc_b_in;
    else if (lit_in[3])
      acc_add = acc_add <<< (5'h10 - {1'b0, lit_in[3:0]});
    else
      acc_add = $signed(acc_add) >>> lit_in[2:0];
    acc_sum    = {acc_src[ACC_W-1], acc_src} + {acc_add[ACC_W-1], acc_add};
    sat        = acc_sum[ACC_W] != acc_sum[ACC_W-1];
    acc_out    = acc_sum[ACC_W-1:0];
    result_out = a_in;
    flags_out  = flags_in;
    case (op_in)
      OP_ADD, OP_ADD_WITH_CARRY:
      begin
        result_out       = sum[DATA_W-1:0];
        flags_out        = set_nz(flags_in, sum[DATA_W-1:0]);
        flags_out[FL_C]  = sum[DATA_W];
        flags_out[FL_DC] = low_sum[8];
        flags_out[FL_OV] = (a_in[15] == b_in[15]) && (sum[15] != a_in[15]);
      end
      OP_AND:
      begin
        result_out = a_in & b_in;
        flags_out  = set_nz(flags_in, a_in & b_in);
      end
      OP_ASR1:
      begin
        result_out       = {a_in[15], a_in[15:1]};
        flags_out        = set_nz(flags_in, {a_in[15], a_in[15:1]});
        flags_out[FL_C]  = a_in[0];
        flags_out[FL_OV] = 1'b0;
      end
      OP_ASR_W:
      begin
        result_out = $signed(a_in) >>> b_in[3:0];
        flags_out  = set_nz(flags_in, $signed(a_in) >>> b_in[3:0]);
      end
      OP_ASR_LIT:
      begin
        result_out = $signed(a_in) >>> lit_in;
        flags_out  = set_nz(flags_in, $signed(a_in) >>> lit_in);
      end
      OP_BIT_CLEAR_OP:
        result_out = a_in & ~(16'h0001 << b_in[3:0]);
      OP_BIT_SET_OP:
        result_out = a_in | (16'h0001 << b_in[3:0]);
      OP_ACC_ADD, OP_ACC_SADD:
      begin
        if (sat)
          acc_out = acc_sum[ACC_W] ? 32'h8000_0000 : 32'h7fff_ffff;
        flags_out[acc_sel_in ? FL_OB : FL_OA] =
          (acc_out[31:23] != 9'h000) && (acc_out[31:23] != 9'h1ff);
        if (sat)
          flags_out[acc_sel_in ? FL_SB : FL_SA] = 1'b1;
      end
      default:
        result_out = a_in;
    endcase
  end

endmodule : exec_alu

// ===== logic/branch_cond.sv
// branch condition evaluation from the current flags
module branch_cond
  import exec_pkg::*;
(
  // condition and flags
  input  wire exec_pkg::cond_t        cond_in,
  input  wire logic [DATA_W-1:0]      flags_in,
  // outcome
  output logic                        take_out,
  output logic                        acc_cond_out
);

  logic c;
  logic z;
  logic n;
  logic v;

  // ****************************************
  // condition table
  // ****************************************
  always_comb
  begin
    c            = flags_in[FL_C];
    z            = flags_in[FL_Z];
    n            = flags_in[FL_N];
    v            = flags_in[FL_OV];
    acc_cond_out = 1'b0;
    case (cond_in)
      CND_C:        take_out = c;
      CND_GE:       take_out = (n == v);
      CND_GEU:      take_out = c;
      CND_GT:       take_out = !z && (n == v);
      CND_GTU:      take_out = c && !z;
      CND_LE:       take_out = z || (n != v);
      CND_LEU:      take_out = !c || z;
      CND_LT:       take_out = (n != v);
      CND_LTU:      take_out = !c;
      CND_N:        take_out = n;
      CND_NC:       take_out = !c;
      CND_NN:       take_out = !n;
      CND_NOV:      take_out = !v;
      CND_NZ:       take_out = !z;
      CND_OV:       take_out = v;
      CND_Z:        take_out = z;
      CND_OA:
      begin
        take_out     = flags_in[FL_OA];
        acc_cond_out = 1'b1;
      end
      CND_OB:
      begin
        take_out     = flags_in[FL_OB];
        acc_cond_out = 1'b1;
      end
      CND_SA:
      begin
        take_out     = flags_in[FL_SA];
        acc_cond_out = 1'b1;
      end
      CND_SB:
      begin
        take_out     = flags_in[FL_SB];
        acc_cond_out = 1'b1;
      end
      default:      take_out = 1'b1;
    endcase
  end

endmodule : branch_cond

// ===== test/avm_model.sv
// avalon-mm master model for the register bus
module avm_model
(
  // bus answer
  input  wire logic                   clk_in,
  input  wire logic                   wait_in,
  input  wire logic [31:0]            rdata_in,
  // bus request
  output logic [exec_pkg::ADDR_W-1:0] addr_out,
  output logic                        rd_out,
  output logic                        wr_out,
  output logic [31:0]                 wdata_out
);
  timeunit 1ns;
  timeprecision 1ps;
  import exec_pkg::*;
  initial
  begin
    addr_out = '0;
    rd_out = 1'b0;
    wr_out = 1'b0;
    wdata_out = '0;
  end
  // one access, held until waitrequest is sampled low
  task automatic xfer(input logic w, input logic [ADDR_W-1:0] ad,
                      input logic [31:0] d, output logic [31:0] v);
    addr_out <= ad;
    wdata_out <= d;
    rd_out <= !w;
    wr_out <= w;
    @(posedge clk_in);
    while (wait_in !== 1'b0)
      @(posedge clk_in);
    v = rdata_in;
    rd_out <= 1'b0;
    wr_out <= 1'b0;
    @(posedge clk_in);
  endtask : xfer
endmodule : avm_model

// ===== test/tb.sv
// self-checking bench for the execution unit
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import exec_pkg::*;
  logic              clk = 1'b0;
  logic              arst_n = 1'b0;
  logic [ADDR_W-1:0] addr;
  logic              rd;
  logic              wr;
  logic              wt;
  logic [31:0]       wd;
  logic [31:0]       rdat;
  logic [ADDR_W-1:0] addr2;
  logic              rd2;
  logic              wr2;
  logic              wt2;
  logic [31:0]       wd2;
  logic [31:0]       rdat2;
  logic [31:0]       v2;
  logic [15:0]       a;
  logic [15:0]       b;
  logic [15:0]       f;
  logic [15:0]       r;
  logic [3:0]        s;
  cond_t             cl[6] = '{CND_Z, CND_NZ, CND_ALWAYS, CND_OA, CND_SA, CND_COMPUTED};
  logic [5:0]        tk = 6'b110101;
  int                n_fail = 0;
  int                samples_checked = 0;
  int                seed = 32'ha4c8;
  always #20 clk = ~clk;
  exec_core #(.MOTOR_VARIANT(1'b1)) dut_u (.CLK_IN(clk), .ARST_N_IN(arst_n),
    .AVS_ADDRESS_IN(addr), .AVS_READ_IN(rd), .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wd),
    .AVS_READDATA_OUT(rdat), .AVS_WAITREQUEST_OUT(wt));
  avm_model mst_u (.clk_in(clk), .wait_in(wt), .rdata_in(rdat), .addr_out(addr),
    .rd_out(rd), .wr_out(wr), .wdata_out(wd));
  exec_core #(.MOTOR_VARIANT(1'b0)) plain_u (.CLK_IN(clk), .ARST_N_IN(arst_n),
    .AVS_ADDRESS_IN(addr2), .AVS_READ_IN(rd2), .AVS_WRITE_IN(wr2), .AVS_WRITEDATA_IN(wd2),
    .AVS_READDATA_OUT(rdat2), .AVS_WAITREQUEST_OUT(wt2));
  avm_model mst2_u (.clk_in(clk), .wait_in(wt2), .rdata_in(rdat2), .addr_out(addr2),
    .rd_out(rd2), .wr_out(wr2), .wdata_out(wd2));
  // ****************
  // expectations and bus tasks
  // ****************
  function automatic logic [31:0] add_exp(input logic [15:0] x, y, input logic ci);
    logic [16:0] t;
    logic [8:0]  l;
    t = {1'b0, x} + {1'b0, y} + 17'(ci);
    l = {1'b0, x[7:0]} + {1'b0, y[7:0]} + 9'(ci);
    return {11'h0, l[8], t[15], x[15] == y[15] && t[15] != x[15], t[15:0] == 16'h0,
            t[16], t[15:0]};
  endfunction : add_exp
  function automatic logic [31:0] nz_exp(input logic [15:0] v, fl);
    return {11'h0, fl[4], v[15], fl[2], v == 16'h0, fl[0], v};
  endfunction : nz_exp
  task automatic chk(input logic [31:0] got, input logic [31:0] ev);
    samples_checked++;
    if (got !== ev)
    begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, ev);
    end
  endtask : chk
  task automatic wr32(input logic [ADDR_W-1:0] ad, input logic [31:0] d);
    logic [31:0] v;
    mst_u.xfer(1'b1, ad, d, v);
  endtask : wr32
  task automatic rdc(input logic [ADDR_W-1:0] ad, input logic [31:0] m, ev);
    logic [31:0] v;
    mst_u.xfer(1'b0, ad, 32'h0, v);
    chk(v & m, ev & m);
  endtask : rdc
  task automatic op(input logic [31:0] cmd, ex, m, input logic [3:0] st);
    wr32(OFS_FLAGS, {16'h0, f});
    wr32(OFS_OPA, {16'h0, a});
    wr32(OFS_OPB, {16'h0, b});
    wr32(OFS_CMD, cmd);
    wr32(OFS_OPB, {16'h0, b});
    rdc(OFS_RESULT, {16'h0, m[15:0]}, {16'h0, ex[15:0]});
    rdc(OFS_FLAGS, {16'h0, m[31:16]}, {16'h0, ex[31:16]});
    rdc(OFS_STAT, 32'h3c, {26'h0, st, 2'h0});
  endtask : op
  task automatic summarize();
    $display("checked=%0d failed=%0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : summarize
  // ****************
  // scenarios
  // ****************
  initial
  begin
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    rdc(OFS_STAT, 32'hffff_ffff, 32'h0);
    wr32(6'h3c, 32'hffff_ffff);
    rdc(6'h3c, 32'hffff_ffff, 32'h0);
    for (int i = 0; i < 10; i++)
    begin
      a = 16'($random(seed));
      b = 16'($random(seed));
      f = 16'($random(seed)) & 16'h001f;
      if (i < 2)
        a = 16'h7fff;
      s = b[3:0];
      r = {a[15], a[15:1]};
      op({27'h0, OP_ADD}, add_exp(a, b, 1'b0), 32'h001f_ffff, 4'h2);
      op({27'h0, OP_ADD_WITH_CARRY}, add_exp(a, b, f[0]), 32'h001f_ffff, 4'h2);
      op({27'h0, OP_ASR1}, nz_exp(r, {f[15:3], 1'b0, f[1], a[0]}), 32'h001f_ffff, 4'h2);
      r = 16'($signed(a) >>> s);
      op({27'h0, OP_ASR_W}, nz_exp(r, f), 32'h001f_ffff, 4'h2);
      op({16'h0, s, 7'h40, OP_ASR_LIT}, nz_exp(r, f), 32'h001f_ffff, 4'h2);
      op({27'h0, OP_AND}, nz_exp(a & b, f), 32'h001f_ffff, 4'h2);
      op({27'h0, OP_BIT_SET_OP}, {11'h0, f[4:0], a | (16'h1 << s)}, 32'h001f_ffff, 4'h2);
      op({27'h0, OP_BIT_CLEAR_OP}, {11'h0, f[4:0], a & ~(16'h1 << s)}, 32'h001f_ffff, 4'h2);
      op({21'h0, 1'b1, 5'h0, OP_ADD}, add_exp(a, b, 1'b0), 32'h001f_ffff, 4'h4);
    end
    f = 16'h0402;
    for (int i = 0; i < 6; i++)
    begin
      op({22'h0, cl[i], OP_BRANCH}, {f, 16'h0}, 32'hffff_0000, tk[i] ? 4'h9 : 4'h2);
      if (tk[i])
        rdc(OFS_PC, 32'hffff, {16'h0, a});
    end
    f = 16'h0;
    wr32(OFS_ACCA, 32'h0001_2345);
    wr32(OFS_ACCB, 32'h0000_1111);
    op({27'h0, OP_ACC_ADD}, 32'h0, 32'h0f1f_0000, 4'h2);
    rdc(OFS_ACCA, 32'hffff_ffff, 32'h0001_3456);
    wr32(OFS_ACCA, 32'h0080_0000);
    wr32(OFS_ACCB, 32'h0);
    op({27'h0, OP_ACC_ADD}, 32'h0100_0000, 32'h0f1f_0000, 4'h2);
    wr32(OFS_ACCA, 32'h7fff_ffff);
    wr32(OFS_ACCB, 32'h0000_0001);
    op({27'h0, OP_ACC_ADD}, 32'h0500_0000, 32'h0f1f_0000, 4'h2);
    rdc(OFS_ACCA, 32'hffff_ffff, 32'h7fff_ffff);
    a = 16'h0010;
    wr32(OFS_ACCB, 32'h0);
    op(32'h0002_c009, 32'h0, 32'h0f1f_0000, 4'h2);
    rdc(OFS_ACCB, 32'hffff_ffff, 32'h0000_0100);
    // plain variant refuses accumulator operations
    mst2_u.xfer(1'b1, OFS_ACCA, 32'h0000_0055, v2);
    mst2_u.xfer(1'b1, OFS_CMD, {27'h0, OP_ACC_ADD}, v2);
    mst2_u.xfer(1'b0, OFS_STAT, 32'h0, v2);
    chk(v2 & 32'h3e, 32'h0000_000a);
    mst2_u.xfer(1'b0, OFS_ACCA, 32'h0, v2);
    chk(v2, 32'h0000_0055);
    summarize();
  end
  initial
  begin
    #400000;
    n_fail++;
    summarize();
  end
endmodule : tb
